/* rcs_regs.sv */
// Purpose: Control and status registers of a battery-backed real-time clock
// Assumes: Multiplexed bus in strobe mode, pins synchronised here
// Notes:   POR restores battery-held bits; RST only clears interrupt and wave enables and flags
//
// Functional notes
// - Registers decoded at 0x0a to 0x0d, usable even during an update.
// - Four-bit rate select picks one of 13 rates for wave and tick.
// - Rate code zero disables both; codes three to six give kilohertz rates.
// - Oscillator code 010 runs oscillator and divider for timekeeping.
// - Oscillator code 11X runs oscillator with divider held.
// - Any other oscillator code keeps the oscillator stopped.
// - After writing 010 the first update follows 500 ms later.
// - Update-pending bit is read-only, set before and cleared after updates.
// - Update-pending reads zero whenever the transfer hold is set.
// - Every bit of the interrupt and format register is read/write, except bit 4, which reads zero while bit 7 is set.
// - Reset clears interrupt enables, wave enable and all event flags only.
// - Daylight saving falls back to 1:00:00 on last October Sunday.
// - Daylight saving springs from 2:00:00 to 3:00:00 on first April Sunday.
// - Hour mode bit: one means 24-hour, zero 12-hour, time and alarm.
// - Number format bit: one means binary, zero BCD.
// - Wave enable passes the rate to the pin, else pin held low.
// - Enables 6, 5, 4 allow periodic, alarm and update interrupts.
// - Transfer hold stops buffer copy and clears the update enable.
// - Event-flag register is read-only with bits 0 to 3 zero.
// - Update-done flag sets at every update end regardless of enable.
// - Alarm flag sets on alarm event regardless of enable.
// - Alarm event is an update with all three bytes matching or ignored.
// - Periodic flag sets once per selected period.
// - Pending flag sets when any event flag meets its enable.
// - Reading the event-flag register returns flags, then clears them.
// - Backup register is read-only with bits 0 to 6 zero.
// - Backup bit reads one when the energy source is valid.
`timescale 1ns/100ps
module rcs_regs
  import rcs_pkg::*;
#(
  parameter int OSC_DIV = RCS_OSC_DIV
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       POR,
  input  wire logic [7:0] AD_IN,
  output logic      [7:0] AD_OUT,
  output logic            AD_OE_N,
  input  wire logic       AS,
  input  wire logic       DS,
  input  wire logic       RW,
  input  wire logic       CS_N,
  input  wire logic       ALARM_MATCH,
  input  wire logic       BACKUP_OK,
  output logic            IRQ_N,
  output logic            SQUARE_WAVE_PIN,
  output logic            UPDATE_PENDING,
  output logic            UPDATE_STROBE,
  output logic            COPY_ENABLE,
  output logic            HOUR_24,
  output logic            BINARY_FMT,
  output logic            DST_ENABLE
);

  rcs_top_t             s_reg;
  rcs_top_t             s_next;
  logic [RCS_DIV_W-1:0] div_cnt;
  logic                 sec_tick;
  logic                 tap_level;
  logic                 per_tick;
  logic                 osc_on;
  logic                 div_run;

  // -----------------------------------------------------------------------
  // Oscillator and divider decode
  // -----------------------------------------------------------------------
  assign div_run = (s_reg.ctrl.clock_source_control == RCS_OSC_RUN);
  assign osc_on  = div_run
                 | (s_reg.ctrl.clock_source_control[2:1] == RCS_OSC_HOLD);

  rcs_osc_div #(
    .OSC_DIV (OSC_DIV)
  ) u_div (
    .clk        (CLK),
    .por        (POR),
    .osc_on     (osc_on),
    .div_run    (div_run),
    .div_preset (s_reg.preset),
    .cnt        (div_cnt),
    .sec_tick   (sec_tick)
  );

  rcs_rate_tap u_tap (
    .clk         (CLK),
    .por         (POR),
    .rate_select (s_reg.ctrl.rate_select),
    .cnt         (div_cnt),
    .level       (tap_level),
    .per_tick    (per_tick)
  );

  // -----------------------------------------------------------------------
  // Read data
  // -----------------------------------------------------------------------
  function automatic logic [7:0] rd_mux(input logic [7:0] a, input rcs_ctrl_t c,
                                        input rcs_flags_t f, input logic pend,
                                        input logic bk);
    if (a == RCS_OFF_RATE) begin
      return {pend, c.clock_source_control, c.rate_select};
    end else if (a == RCS_OFF_CTRL) begin
      return {c.update_transfer_hold, c.periodic_irq_enable, c.alarm_irq_enable,
              c.update_irq_enable, c.square_wave_enable, c.number_format_select,
              c.hour_mode_select, c.daylight_saving_enable};
    end else if (a == RCS_OFF_FLAGS) begin
      return {f, 4'h0};
    end else if (a == RCS_OFF_BACKUP) begin
      return {bk, 7'h00};
    end else begin
      return 8'h00;
    end
  endfunction

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb begin
    logic ds_fall;
    logic wr;
    logic rd_end;
    logic rd_now;
    logic clr;
    logic cond;
    ds_fall = 1'b0;
    wr      = 1'b0;
    rd_end  = 1'b0;
    rd_now  = 1'b0;
    clr     = 1'b0;
    cond    = 1'b0;
    s_next  = s_reg;
    s_next.upd_strobe = 1'b0;
    s_next.preset     = 1'b0;

    // Two-stage pin synchronisers
    s_next.s1    = '{as: AS, ds: DS, rw: RW, cs_n: CS_N};
    s_next.s2    = s_reg.s1;
    s_next.prev  = s_reg.s2;
    s_next.ad_s1 = AD_IN;
    s_next.ad_s2 = s_reg.ad_s1;
    s_next.bk_s1 = BACKUP_OK;
    s_next.bk_s2 = s_reg.bk_s1;

    // Address follows AD while AS is high, frozen at its fall
    if (s_reg.s2.as) begin
      s_next.addr = s_reg.ad_s2;
    end
    // Data and cycle type follow while DS is high, used at its fall
    if (s_reg.s2.ds) begin
      s_next.wdata  = s_reg.ad_s2;
      s_next.cyc_rw = s_reg.s2.rw;
      s_next.cyc_cs = ~s_reg.s2.cs_n;
    end
    ds_fall = s_reg.prev.ds & ~s_reg.s2.ds;
    wr      = ds_fall & s_reg.cyc_cs & ~s_reg.cyc_rw;
    rd_end  = ds_fall & s_reg.cyc_cs & s_reg.cyc_rw;
    rd_now  = s_reg.s2.ds & ~s_reg.s2.cs_n & s_reg.s2.rw;

    // Access is never gated by the update cycle
    s_next.ad_oe_n = ~rd_now;
    s_next.ad_out  = rd_now ? rd_mux(s_reg.addr, s_reg.ctrl, s_reg.flags,
                                     s_reg.pending, s_reg.bk_s2) : 8'h00;

    // Register writes; bit 7 of the rate register is ignored
    if (wr && (s_reg.addr == RCS_OFF_RATE)) begin
      s_next.ctrl.rate_select          = s_reg.wdata[RCS_RS_HI:0];
      s_next.ctrl.clock_source_control = s_reg.wdata[RCS_OSC_HI:RCS_OSC_LO];
      s_next.preset = (s_reg.wdata[RCS_OSC_HI:RCS_OSC_LO] == RCS_OSC_RUN)
                    & (s_reg.ctrl.clock_source_control != RCS_OSC_RUN);
    end else if (wr && (s_reg.addr == RCS_OFF_CTRL)) begin
      {s_next.ctrl.update_transfer_hold, s_next.ctrl.periodic_irq_enable,
       s_next.ctrl.alarm_irq_enable, s_next.ctrl.update_irq_enable,
       s_next.ctrl.square_wave_enable, s_next.ctrl.number_format_select,
       s_next.ctrl.hour_mode_select, s_next.ctrl.daylight_saving_enable} = s_reg.wdata;
    end
    if (s_next.ctrl.update_transfer_hold) begin
      s_next.ctrl.update_irq_enable = 1'b0;
    end

    // Update cycle sequencing
    if (sec_tick) begin
      s_next.busy    = 1'b1;
      s_next.upd_cnt = '0;
      s_next.pending = 1'b1;
    end else if (s_reg.busy) begin
      if (s_reg.upd_cnt == RCS_UPD_LAST) begin
        s_next.busy       = 1'b0;
        s_next.pending    = 1'b0;
        s_next.upd_strobe = 1'b1;
      end else begin
        s_next.upd_cnt = s_reg.upd_cnt + 4'h1;
      end
    end
    if (s_next.ctrl.update_transfer_hold) begin
      s_next.pending = 1'b0;
    end

    // Event flags: a set in the clearing cycle wins
    clr = rd_end & (s_reg.addr == RCS_OFF_FLAGS);
    s_next.flags.update_done_flag = (s_reg.flags.update_done_flag & ~clr)
                                  | s_next.upd_strobe;
    s_next.flags.alarm_flag = (s_reg.flags.alarm_flag & ~clr)
                            | (s_next.upd_strobe & ALARM_MATCH);
    s_next.flags.periodic_flag = (s_reg.flags.periodic_flag & ~clr)
                               | per_tick;
    cond = (s_next.ctrl.periodic_irq_enable & s_next.flags.periodic_flag)
         | (s_next.ctrl.alarm_irq_enable & s_next.flags.alarm_flag)
         | (s_next.ctrl.update_irq_enable & s_next.flags.update_done_flag);
    s_next.flags.irq_pending_flag = (s_reg.flags.irq_pending_flag & ~clr)
                                  | cond;

    // Reset: POR zeroes all state except ad_oe_n and irq_n, which it sets high; on RST battery-held bits keep their values
    if (POR) begin
      s_next         = '0;
      s_next.ad_oe_n = 1'b1;
      s_next.ctrl.rate_select          = RCS_RS_POR;
      s_next.ctrl.clock_source_control = RCS_OSC_POR;
    end else if (RST) begin
      s_next.ctrl.periodic_irq_enable = 1'b0;
      s_next.ctrl.alarm_irq_enable    = 1'b0;
      s_next.ctrl.update_irq_enable   = 1'b0;
      s_next.ctrl.square_wave_enable  = 1'b0;
      s_next.flags                    = '0;
      s_next.ad_oe_n                  = 1'b1;
      s_next.ad_out                   = 8'h00;
    end

    s_next.irq_n = ~s_next.flags.irq_pending_flag;
    s_next.square_wave_pin = s_next.ctrl.square_wave_enable & tap_level;
  end

  always_ff @(posedge CLK) begin
    s_reg <= s_next;
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign AD_OUT         = s_reg.ad_out;
  assign AD_OE_N        = s_reg.ad_oe_n;
  assign IRQ_N          = s_reg.irq_n;
  assign SQUARE_WAVE_PIN = s_reg.square_wave_pin;
  assign UPDATE_PENDING = s_reg.pending;
  assign UPDATE_STROBE  = s_reg.upd_strobe;
  assign COPY_ENABLE    = ~s_reg.ctrl.update_transfer_hold;
  assign HOUR_24        = s_reg.ctrl.hour_mode_select;
  assign BINARY_FMT     = s_reg.ctrl.number_format_select;
  assign DST_ENABLE     = s_reg.ctrl.daylight_saving_enable;

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  a_pending_hold_zero: assert property (@(posedge CLK) disable iff (RST || POR)
    s_reg.ctrl.update_transfer_hold |-> !UPDATE_PENDING)
    else $error("update pending set while transfer hold");

  a_hold_enable_clear: assert property (@(posedge CLK) disable iff (RST || POR)
    s_reg.ctrl.update_transfer_hold |-> !s_reg.ctrl.update_irq_enable && !COPY_ENABLE)
    else $error("update enable or copy active under hold");

  a_update_length: assert property (@(posedge CLK) disable iff (RST || POR)
    $rose(s_reg.busy) |-> s_reg.busy [*8] ##1 (!s_reg.busy && UPDATE_STROBE))
    else $error("update cycle length wrong");

  a_update_flag_set: assert property (@(posedge CLK) disable iff (RST || POR)
    UPDATE_STROBE |-> s_reg.flags.update_done_flag)
    else $error("update done flag not set at update end");

  a_alarm_flag_set: assert property (@(posedge CLK) disable iff (RST || POR)
    (s_next.upd_strobe && ALARM_MATCH) |=> s_reg.flags.alarm_flag)
    else $error("alarm flag missed");

  a_period_flag_set: assert property (@(posedge CLK) disable iff (RST || POR)
    per_tick |=> s_reg.flags.periodic_flag)
    else $error("periodic flag missed");

  a_irq_pin_level: assert property (@(posedge CLK) disable iff (RST || POR)
    IRQ_N == !s_reg.flags.irq_pending_flag)
    else $error("interrupt pin disagrees with pending flag");

  a_flag_read_clear: assert property (@(posedge CLK) disable iff (RST || POR)
    (s_reg.prev.ds && !s_reg.s2.ds && s_reg.cyc_cs && s_reg.cyc_rw
     && s_reg.addr == RCS_OFF_FLAGS && !per_tick && !sec_tick && !s_reg.busy)
    |=> (s_reg.flags == '0))
    else $error("flags not cleared by read");

  a_wave_low_off: assert property (@(posedge CLK) disable iff (RST || POR)
    !s_reg.ctrl.square_wave_enable |-> !SQUARE_WAVE_PIN)
    else $error("square wave pin not held low");

  a_wave_rate_off: assert property (@(posedge CLK) disable iff (RST || POR)
    (s_reg.ctrl.rate_select == RCS_RS_OFF) |-> ##2 !SQUARE_WAVE_PIN)
    else $error("square wave pin active at rate zero");

  a_unused_bits_zero: assert property (@(posedge CLK) disable iff (RST || POR)
    (!AD_OE_N && $past(s_reg.addr) == RCS_OFF_FLAGS) |-> (AD_OUT[3:0] == 4'h0))
    else $error("unused flag bits not zero");

endmodule // rcs_regs

/* rcs_pkg.sv */
// Purpose: Shared constants and types for the RTC control and status registers
// Assumes: 250 MHz CLK, 32.768 kHz time base made from CLK by a divider
// Notes:   Offsets, field positions, power-on codes and counts live here
package rcs_pkg;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] RCS_OFF_RATE   = 8'h0a;
  localparam logic [7:0] RCS_OFF_CTRL   = 8'h0b;
  localparam logic [7:0] RCS_OFF_FLAGS  = 8'h0c;
  localparam logic [7:0] RCS_OFF_BACKUP = 8'h0d;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int RCS_PEND_BIT   = 7;
  localparam int RCS_OSC_HI     = 6;
  localparam int RCS_OSC_LO     = 4;
  localparam int RCS_RS_HI      = 3;
  localparam int RCS_IRQ_BIT    = 7;
  localparam int RCS_BACKUP_BIT = 7;

  // ---------------------------------------------------------------------
  // Codes and power-on values
  // ---------------------------------------------------------------------
  localparam logic [2:0] RCS_OSC_RUN  = 3'h2;
  localparam logic [1:0] RCS_OSC_HOLD = 2'h3;
  localparam logic [3:0] RCS_RS_OFF   = 4'h0;
  localparam logic [3:0] RCS_RS_POR   = 4'h0;
  localparam logic [2:0] RCS_OSC_POR  = 3'h0;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int RCS_CLK_HZ          = 250_000_000;
  localparam int RCS_OSC_HZ          = 32768;
  localparam int RCS_OSC_DIV         = RCS_CLK_HZ / RCS_OSC_HZ;
  localparam int RCS_PRESC_W         = 13;
  localparam int RCS_DIV_W           = 15;
  localparam int RCS_FIRST_UPDATE_MS = 500;
  localparam int RCS_FIRST_UPDATE_TK = RCS_OSC_HZ * RCS_FIRST_UPDATE_MS / 1000;
  localparam logic [RCS_DIV_W-1:0] RCS_DIV_PRESET =
    RCS_DIV_W'(RCS_OSC_HZ - RCS_FIRST_UPDATE_TK);
  localparam int RCS_UPD_CW          = 4;
  localparam logic [RCS_UPD_CW-1:0] RCS_UPD_LAST = 4'h7;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic as;
    logic ds;
    logic rw;
    logic cs_n;
  } rcs_bus_t;

  typedef struct packed {
    logic [3:0] rate_select;
    logic [2:0] clock_source_control;
    logic       update_transfer_hold;
    logic       periodic_irq_enable;
    logic       alarm_irq_enable;
    logic       update_irq_enable;
    logic       square_wave_enable;
    logic       number_format_select;
    logic       hour_mode_select;
    logic       daylight_saving_enable;
  } rcs_ctrl_t;

  typedef struct packed {
    logic irq_pending_flag;
    logic periodic_flag;
    logic alarm_flag;
    logic update_done_flag;
  } rcs_flags_t;

  typedef struct packed {
    logic [RCS_PRESC_W-1:0] presc;
    logic [RCS_DIV_W-1:0]   cnt;
    logic                   tick;
    logic                   sec;
  } rcs_div_t;

  typedef struct packed {
    logic prev;
    logic level;
    logic per;
  } rcs_tap_t;

  typedef struct packed {
    rcs_bus_t              s1;
    rcs_bus_t              s2;
    rcs_bus_t              prev;
    logic [7:0]            ad_s1;
    logic [7:0]            ad_s2;
    logic                  bk_s1;
    logic                  bk_s2;
    logic [7:0]            addr;
    logic [7:0]            wdata;
    logic                  cyc_rw;
    logic                  cyc_cs;
    logic [7:0]            ad_out;
    logic                  ad_oe_n;
    rcs_ctrl_t             ctrl;
    rcs_flags_t            flags;
    logic                  pending;
    logic                  busy;
    logic [RCS_UPD_CW-1:0] upd_cnt;
    logic                  upd_strobe;
    logic                  preset;
    logic                  irq_n;
    logic                  square_wave_pin;
  } rcs_top_t;

endpackage

/* rcs_osc_div.sv */
// Purpose: 32.768 kHz time base and 15-stage divider with 1 Hz update tick
// Assumes: Same clock as the register block; por is synchronous
// Notes:   Prescale ratio is integer, so the time base is slightly fast
`timescale 1ns/100ps
module rcs_osc_div
  import rcs_pkg::*;
#(
  parameter int OSC_DIV = RCS_OSC_DIV
) (
  input  wire logic                 clk,
  input  wire logic                 por,
  input  wire logic                 osc_on,
  input  wire logic                 div_run,
  input  wire logic                 div_preset,
  output logic      [RCS_DIV_W-1:0] cnt,
  output logic                      sec_tick
);

  rcs_div_t s_reg;
  rcs_div_t s_next;

  // -----------------------------------------------------------------------
  // Time base and divider chain
  // -----------------------------------------------------------------------
  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    s_next.sec  = 1'b0;
    if (osc_on) begin
      if (s_reg.presc == RCS_PRESC_W'(OSC_DIV - 1)) begin
        s_next.presc = '0;
        s_next.tick  = 1'b1;
      end else begin
        s_next.presc = s_reg.presc + 13'h1;
      end
    end
    // Preset shortens the first second to half
    if (div_preset) begin
      s_next.cnt = RCS_DIV_PRESET;
    end else if (!div_run) begin
      s_next.cnt = '0;
    end else if (s_reg.tick) begin
      s_next.cnt = s_reg.cnt + 15'h1;
      s_next.sec = (s_reg.cnt == '1);
    end
    if (por) begin
      s_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  assign cnt      = s_reg.cnt;
  assign sec_tick = s_reg.sec;

endmodule // rcs_osc_div

/* rcs_rate_tap.sv */
// Purpose: Selects the divider stage for the square wave and periodic tick
// Assumes: Divider count advances at 32.768 kHz
// Notes:   Codes 1 and 2 reuse the stages of codes 8 and 9
`timescale 1ns/100ps
module rcs_rate_tap
  import rcs_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 por,
  input  wire logic [3:0]           rate_select,
  input  wire logic [RCS_DIV_W-1:0] cnt,
  output logic                      level,
  output logic                      per_tick
);

  rcs_tap_t s_reg;
  rcs_tap_t s_next;

  function automatic logic [3:0] tap_index(input logic [3:0] rs);
    if (rs == 4'h1) begin
      return 4'h6;
    end else if (rs == 4'h2) begin
      return 4'h7;
    end else begin
      return rs - 4'h2;
    end
  endfunction

  // -----------------------------------------------------------------------
  // Stage select and rising-edge tick
  // -----------------------------------------------------------------------
  always_comb begin
    logic bit_now;
    bit_now = 1'b0;
    s_next  = s_reg;
    if (rate_select != RCS_RS_OFF) begin
      bit_now = cnt[tap_index(rate_select)];
    end
    s_next.prev  = bit_now;
    s_next.level = bit_now;
    s_next.per   = bit_now & ~s_reg.prev;
    if (por) begin
      s_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  assign level    = s_reg.level;
  assign per_tick = s_reg.per;

endmodule // rcs_rate_tap

/* rcs_cpu_model.sv */
// Purpose: Bus master model for the control and status registers
// Assumes: Strobe-mode multiplexed bus, each phase held 3+ CLK
// Notes:   Released address/data lines show the inverted last value
`timescale 1ns/100ps
module rcs_cpu_model
  import rcs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] rd,
  output logic      [7:0] ad,
  output rcs_bus_t        bus
);
  initial begin
    ad = 8'h00;
    bus = '{as: 1'b0, ds: 1'b0, rw: 1'b1, cs_n: 1'b1};
  end

  // One full cycle: address phase, then data phase
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk);
    bus.as <= 1'b1;
    bus.cs_n <= 1'b0;
    ad <= a;
    repeat (4) @(posedge clk);
    bus.as <= 1'b0;
    repeat (3) @(posedge clk);
    bus.rw <= ~wr;
    bus.ds <= 1'b1;
    ad <= wr ? d : ~a;
    repeat (6) @(posedge clk);
    q = rd;
    bus.ds <= 1'b0;
    repeat (4) @(posedge clk);
    bus.cs_n <= 1'b1;
    bus.rw <= 1'b1;
    ad <= ~ad;
  endtask
endmodule // rcs_cpu_model

/* test_rcs_regs.sv */
// Purpose: Self-checking bench for the control and status registers
// Assumes: OSC_DIV of 2 keeps the first update near 32768 cycles
// Notes:   Bus traffic goes through the master model
`timescale 1ns/100ps
module test_rcs_regs
  import rcs_pkg::*;
;
  localparam int DIV = 2;
  logic       CLK, RST, POR, ALARM_MATCH, BACKUP_OK;
  logic [7:0] cpu_ad, ad_out, ad_wire, q;
  rcs_bus_t   bus;
  logic       ad_oe_n, irq_n, sq_pin, upd_pend, upd_stb, copy_en, hr24, bin, dst, seen;
  int         n_errors, cmp_count;

  assign ad_wire = ad_oe_n ? cpu_ad : ad_out;

  rcs_regs #(.OSC_DIV(DIV)) rcs_regs_inst (.CLK(CLK), .RST(RST), .POR(POR),
    .AD_IN(ad_wire), .AD_OUT(ad_out), .AD_OE_N(ad_oe_n), .AS(bus.as), .DS(bus.ds),
    .RW(bus.rw), .CS_N(bus.cs_n), .ALARM_MATCH(ALARM_MATCH), .BACKUP_OK(BACKUP_OK),
    .IRQ_N(irq_n), .SQUARE_WAVE_PIN(sq_pin), .UPDATE_PENDING(upd_pend),
    .UPDATE_STROBE(upd_stb),
    .COPY_ENABLE(copy_en), .HOUR_24(hr24), .BINARY_FMT(bin), .DST_ENABLE(dst));
  rcs_cpu_model rcs_cpu_model_inst (.clk(CLK), .rd(ad_wire), .ad(cpu_ad), .bus(bus));

  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rcs_cpu_model_inst.xfer(a, 1'b1, d, q);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    rcs_cpu_model_inst.xfer(a, 1'b0, 8'h00, q);
    chk(nm, e, q);
  endtask

  // Wait for 0: irq low, 1: update strobe, 2: square wave high
  task automatic wait_on(input int sel, input int lim);
    int i = 0;
    while (i < lim && !(sel == 0 ? irq_n === 1'b0 : sel == 1 ? upd_stb === 1'b1 :
                        sq_pin === 1'b1)) begin
      if (upd_pend === 1'b1) seen = 1'b1;
      @(posedge CLK);
      i++;
    end
    if (i == lim) begin
      n_errors++;
      $display("[FAIL] wait %0d timed out", sel);
      finish_test();
    end
  endtask

  initial begin
    RST = 1'b1;
    POR = 1'b1;
    ALARM_MATCH = 1'b0;
    BACKUP_OK = 1'b1;
    seen = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    POR <= 1'b0;
    rd("ctrl_por", RCS_OFF_CTRL, 8'h00);
    wr(RCS_OFF_CTRL, 8'hff);
    rd("ctrl_hold", RCS_OFF_CTRL, 8'hef);
    chk("copy_en", 8'h00, {7'h0, copy_en});
    wr(RCS_OFF_CTRL, 8'h07);
    rd("ctrl_fmt", RCS_OFF_CTRL, 8'h07);
    chk("fmt_pins", 8'h07, {5'h0, bin, hr24, dst});
    chk("copy_on", 8'h01, {7'h0, copy_en});
    $display("test formats done");
    wr(RCS_OFF_RATE, 8'hf0);
    rd("rate_ro", RCS_OFF_RATE, 8'h70);
    wr(RCS_OFF_RATE, 8'h23);
    rd("rate_run", RCS_OFF_RATE, 8'h23);
    rd("flags_per", RCS_OFF_FLAGS, 8'h40);
    wr(RCS_OFF_CTRL, 8'h4f);
    wait_on(0, 100);
    rd("flags_irq", RCS_OFF_FLAGS, 8'hc0);
    wait_on(2, 100);
    wr(RCS_OFF_CTRL, 8'h47);
    repeat (16) begin
      @(posedge CLK);
      chk("wave_off", 8'h00, {7'h0, sq_pin});
    end
    wr(RCS_OFF_RATE, 8'h20);
    rd("flags_last", RCS_OFF_FLAGS, 8'hc0);
    chk("irq_rel", 8'h01, {7'h0, irq_n});
    rd("flags_rs0", RCS_OFF_FLAGS, 8'h00);
    $display("test periodic done");
    ALARM_MATCH <= 1'b1;
    wr(RCS_OFF_CTRL, 8'h07);
    wait_on(1, RCS_FIRST_UPDATE_TK * DIV);
    chk("pend_seen", 8'h01, {7'h0, seen});
    repeat (4) @(posedge CLK);
    rd("flags_upd", RCS_OFF_FLAGS, 8'h30);
    $display("test update done");
    rd("backup_ok", RCS_OFF_BACKUP, 8'h80);
    BACKUP_OK <= 1'b0;
    wr(RCS_OFF_BACKUP, 8'hff);
    rd("backup_low", RCS_OFF_BACKUP, 8'h00);
    rd("unmapped", 8'h0e, 8'h00);
    wr(RCS_OFF_CTRL, 8'hff);
    RST <= 1'b1;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    rd("ctrl_rst", RCS_OFF_CTRL, 8'h87);
    $display("test reset done");
    finish_test();
  end
endmodule // test_rcs_regs
